/* File: hw/lvrx_pkg.sv */
package lvrx_pkg;

  localparam int unsigned NUM_PHASES = 8;
  localparam int unsigned PHASE_W = 3;
  localparam logic [PHASE_W-1:0] PHASE_HALF = 3'h4;
  localparam logic [PHASE_W-1:0] PHASE_STEP = 3'h1;
  localparam logic [PHASE_W-1:0] PHASE_RESET_VAL = 3'h0;
  localparam int unsigned SYNC_DEPTH = 6;
  localparam logic [2:0] SYNC_LAST = 3'h5;
  localparam logic [2:0] SYNC_PRIME = 3'h3;
  localparam logic [2:0] LOCK_RUNS = 3'h4;
  localparam int unsigned WORD_W = 10;
  localparam logic [3:0] FACTOR_MIN = 4'h3;
  localparam logic [3:0] FACTOR_MAX = 4'ha;
  localparam int unsigned OBUF_DEPTH = 2;

  typedef enum logic [4:0] {
    LVRX_MODE_STATIC = 5'h01,
    LVRX_MODE_DPA = 5'h02,
    LVRX_MODE_CDR = 5'h04,
    LVRX_MODE_BYP_SDR = 5'h08,
    LVRX_MODE_BYP_DDR = 5'h10
  } lvrx_mode_t;

  typedef enum logic [1:0] {
    LVRX_AL_TRAIN = 2'h1,
    LVRX_AL_LOCKED = 2'h2
  } lvrx_align_t;

  typedef struct packed {
    logic locked;
    logic [PHASE_W-1:0] phase;
  } lvrx_status_t;

  typedef struct packed {
    logic valid;
    logic [1:0] bits;
  } lvrx_bypass_t;

endpackage : lvrx_pkg

/* File: hw/lvrx_receiver.sv */
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - aligner picks one of eight equally spaced sampling phases, 45 degree steps.
// - chosen phase is the one nearest the data, within one eighth bit.
// - aligner keeps tracking and steps phase when tracking calls for it and phase hold is low.
// - while phase hold is high the selected phase changes only on phase reset or in a mode without the aligner.
// - no training pattern; aligner needs data transitions to settle after reset.
// - lock output shows first lock to the best phase after reset.
// - phase reset clears only the aligner; it retrains on transitions.
// - synchronizer is a one bit wide, six entry FIFO between phase and read clocks.
// - synchronizer absorbs phase offset only, not frequency difference.
// - synchronizer resets on first lock and on the synchronizer reset input.
// - each slip input rising edge inserts one bit of latency; edges before the next bit count as one.
// - realigned words are valid from the first word boundary after the slip edge; the next bit is not counted.
// - slip counter rolls over at the factor; rollover output pulses one cycle.
// - deserializer factor is static 3 to 10; at most 10 bits per word.
// - bypass delivers 1 bit per clock in single rate, 2 in double rate.
// - bypass disables phase alignment and bit slip.
// - static mode disables aligner and FIFO; capture on serial clock rising edge.
// - synchronizer bypassed in static and clock recovery modes; active only in dpa.
// - in dpa mode FIFO written on chosen phase, read on serial clock.
module lvrx_receiver (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ser_in,
  input wire logic ser_clk,
  input wire lvrx_pkg::lvrx_mode_t rx_mode,
  input wire logic [3:0] deser_factor,
  input wire logic phase_hold,
  input wire logic phase_reset,
  input wire logic sync_reset,
  input wire logic slip_ctrl,
  input wire logic out_ready,
  output logic out_valid,
  output logic [lvrx_pkg::WORD_W-1:0] out_word,
  output lvrx_pkg::lvrx_bypass_t bypass_out,
  output lvrx_pkg::lvrx_status_t status,
  output logic slip_rollover,
  output logic overflow
);
  import lvrx_pkg::*;

  function automatic logic [PHASE_W-1:0] first_edge(input logic [NUM_PHASES-1:0] taps);
    logic [PHASE_W-1:0] idx;
    idx = '0;
    for (int i = NUM_PHASES - 2; i >= 0; i--) begin
      if (taps[i] != taps[i+1]) idx = PHASE_W'(i);
    end
    return idx;
  endfunction : first_edge

  function automatic logic [3:0] clamp_factor(input logic [3:0] f);
    return (f < FACTOR_MIN) ? FACTOR_MIN : ((f > FACTOR_MAX) ? FACTOR_MAX : f);
  endfunction : clamp_factor

  // pin synchronisers and link clock edge finder
  logic din_s1_q, din_s2_q, clk_s1_q, clk_s2_q, clk_d_q, slip_d_q;
  logic [NUM_PHASES-1:0] taps_q;
  logic rise, fall, slip_edge;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_d_q <= 1'b0;
      slip_d_q <= 1'b0;
      taps_q <= '0;
    end else begin
      din_s1_q <= ser_in;
      din_s2_q <= din_s1_q;
      clk_s1_q <= ser_clk;
      clk_s2_q <= clk_s1_q;
      clk_d_q <= clk_s2_q;
      slip_d_q <= slip_ctrl;
      taps_q <= {taps_q[NUM_PHASES-2:0], din_s2_q};
    end
  end
  assign rise = clk_s2_q & ~clk_d_q;
  assign fall = ~clk_s2_q & clk_d_q;
  assign slip_edge = slip_ctrl & ~slip_d_q;

  logic is_bypass, use_aligner, use_sync;
  assign is_bypass = (rx_mode == LVRX_MODE_BYP_SDR) || (rx_mode == LVRX_MODE_BYP_DDR);
  assign use_aligner = (rx_mode == LVRX_MODE_DPA) || (rx_mode == LVRX_MODE_CDR);
  assign use_sync = (rx_mode == LVRX_MODE_DPA);

  // phase aligner
  lvrx_align_t al_q, al_d;
  logic [PHASE_W-1:0] sel_q, sel_d, target;
  logic [2:0] runs_q, runs_d;
  logic has_edge, lock_pulse;
  always_comb begin
    al_d = al_q;
    sel_d = sel_q;
    runs_d = runs_q;
    lock_pulse = 1'b0;
    has_edge = |(taps_q ^ {taps_q[NUM_PHASES-1], taps_q[NUM_PHASES-1:1]});
    target = first_edge(taps_q) ^ PHASE_HALF;
    if (phase_reset || !use_aligner) begin
      al_d = LVRX_AL_TRAIN;
      sel_d = PHASE_RESET_VAL;
      runs_d = '0;
    end else if (rise && has_edge) begin
      if (target != sel_q) begin
        runs_d = '0;
        if (!phase_hold) begin
          sel_d = ((target - sel_q) < PHASE_HALF) ? sel_q + PHASE_STEP : sel_q - PHASE_STEP;
        end
      end else if (runs_q != LOCK_RUNS) begin
        runs_d = runs_q + 3'h1;
      end
      case (al_q)
        LVRX_AL_TRAIN: begin
          if (runs_d == LOCK_RUNS) begin
            al_d = LVRX_AL_LOCKED;
            lock_pulse = 1'b1;
          end
        end
        LVRX_AL_LOCKED: al_d = LVRX_AL_LOCKED;
        default: al_d = LVRX_AL_TRAIN;
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      al_q <= LVRX_AL_TRAIN;
      sel_q <= PHASE_RESET_VAL;
      runs_q <= '0;
    end else begin
      al_q <= al_d;
      sel_q <= sel_d;
      runs_q <= runs_d;
    end
  end

  // synchronizer: written at the chosen phase, read one mclk later on the serial clock
  logic [SYNC_DEPTH-1:0] fifo_q, fifo_d;
  logic [2:0] wp_q, wp_d, rp_q, rp_d, fcnt_q, fcnt_d;
  logic primed_q, primed_d, rd_ev_q, sample, fifo_bit, fifo_rd;
  assign sample = taps_q[sel_q];
  always_comb begin
    fifo_d = fifo_q;
    wp_d = wp_q;
    rp_d = rp_q;
    fcnt_d = fcnt_q;
    primed_d = primed_q;
    fifo_rd = 1'b0;
    fifo_bit = fifo_q[rp_q];
    if (sync_reset || lock_pulse || !use_sync) begin
      wp_d = '0;
      rp_d = '0;
      fcnt_d = '0;
      primed_d = 1'b0;
    end else begin
      // both sides run at one rate, so the fill level only wanders with phase
      if (rd_ev_q && primed_q && fcnt_q != '0) begin
        fifo_rd = 1'b1;
        rp_d = (rp_q == SYNC_LAST) ? 3'h0 : rp_q + 3'h1;
        fcnt_d = fcnt_d - 3'h1;
      end
      if (rise && fcnt_q != 3'(SYNC_DEPTH)) begin
        fifo_d[wp_q] = sample;
        wp_d = (wp_q == SYNC_LAST) ? 3'h0 : wp_q + 3'h1;
        fcnt_d = fcnt_d + 3'h1;
      end
      if (fcnt_d >= SYNC_PRIME) primed_d = 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      fifo_q <= '0;
      wp_q <= '0;
      rp_q <= '0;
      fcnt_q <= '0;
      primed_q <= 1'b0;
      rd_ev_q <= 1'b0;
    end else begin
      fifo_q <= fifo_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      fcnt_q <= fcnt_d;
      primed_q <= primed_d;
      rd_ev_q <= rise;
    end
  end

  // bit source per mode, realignment and deserializer
  logic bit_ev, bit_val;
  always_comb begin
    bit_ev = 1'b0;
    bit_val = taps_q[0];
    if (use_sync) begin
      bit_ev = fifo_rd;
      bit_val = fifo_bit;
    end else if (!is_bypass) begin
      bit_ev = rise;
      bit_val = sample;
    end
  end

  logic [WORD_W-1:0] sh_q, sh_d;
  logic [3:0] bcnt_q, bcnt_d, scnt_q, scnt_d, factor;
  logic slip_pend_q, slip_pend_d, roll_d, word_done;
  assign factor = clamp_factor(deser_factor);
  always_comb begin
    sh_d = sh_q;
    bcnt_d = bcnt_q;
    scnt_d = scnt_q;
    slip_pend_d = slip_pend_q;
    roll_d = 1'b0;
    word_done = 1'b0;
    if (is_bypass) begin
      slip_pend_d = 1'b0;
      scnt_d = '0;
      bcnt_d = '0;
    end else begin
      if (slip_edge) begin
        slip_pend_d = 1'b1;
        if (scnt_q == factor - 4'h1) begin
          scnt_d = '0;
          roll_d = 1'b1;
        end else begin
          scnt_d = scnt_q + 4'h1;
        end
      end
      if (bit_ev) begin
        sh_d = {sh_q[WORD_W-2:0], bit_val};
        if (slip_pend_q) begin
          slip_pend_d = slip_edge;
        end else if (bcnt_q == factor - 4'h1) begin
          bcnt_d = '0;
          word_done = 1'b1;
        end else begin
          bcnt_d = bcnt_q + 4'h1;
        end
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sh_q <= '0;
      bcnt_q <= '0;
      scnt_q <= '0;
      slip_pend_q <= 1'b0;
      slip_rollover <= 1'b0;
    end else begin
      sh_q <= sh_d;
      bcnt_q <= bcnt_d;
      scnt_q <= scnt_d;
      slip_pend_q <= slip_pend_d;
      slip_rollover <= roll_d;
    end
  end

  logic [WORD_W-1:0] word_mask, new_word;
  always_comb begin
    word_mask = '0;
    for (int i = 0; i < WORD_W; i++) begin
      word_mask[i] = (4'(i) < factor);
    end
    new_word = sh_d & word_mask;
  end

  // two-entry output buffer
  logic [WORD_W-1:0] obuf_q [OBUF_DEPTH];
  logic [WORD_W-1:0] obuf_d [OBUF_DEPTH];
  logic owp_q, owp_d, orp_q, orp_d, ovf_d;
  logic [1:0] ocnt_q, ocnt_d;
  always_comb begin
    obuf_d = obuf_q;
    owp_d = owp_q;
    orp_d = orp_q;
    ocnt_d = ocnt_q;
    ovf_d = 1'b0;
    if (out_valid && out_ready) begin
      orp_d = ~orp_q;
      ocnt_d = ocnt_d - 2'h1;
    end
    if (word_done) begin
      if (ocnt_q != 2'(OBUF_DEPTH) || (out_valid && out_ready)) begin
        obuf_d[owp_q] = new_word;
        owp_d = ~owp_q;
        ocnt_d = ocnt_d + 2'h1;
      end else begin
        ovf_d = 1'b1;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      obuf_q <= '{default: '0};
      owp_q <= 1'b0;
      orp_q <= 1'b0;
      ocnt_q <= '0;
      overflow <= 1'b0;
    end else begin
      obuf_q <= obuf_d;
      owp_q <= owp_d;
      orp_q <= orp_d;
      ocnt_q <= ocnt_d;
      overflow <= ovf_d;
    end
  end
  assign out_valid = (ocnt_q != '0);
  assign out_word = obuf_q[orp_q];

  // deserializer bypass: one or two bits per serial clock
  logic fall_bit_q, fall_bit_d;
  lvrx_bypass_t byp_d;
  always_comb begin
    byp_d = '0;
    fall_bit_d = fall ? taps_q[0] : fall_bit_q;
    if (is_bypass && rise) begin
      byp_d.valid = 1'b1;
      byp_d.bits = (rx_mode == LVRX_MODE_BYP_DDR) ? {taps_q[0], fall_bit_q} : {1'b0, taps_q[0]};
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      fall_bit_q <= 1'b0;
      bypass_out <= '0;
      status <= '0;
    end else begin
      fall_bit_q <= fall_bit_d;
      bypass_out <= byp_d;
      status <= '{locked: (al_d == LVRX_AL_LOCKED), phase: sel_d};
    end
  end

endmodule : lvrx_receiver
`default_nettype wire

/* File: test/lvrx_receiver_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module lvrx_receiver_monitor (
  input wire logic mclk,
  input wire logic rst_b,
  input wire lvrx_pkg::lvrx_mode_t rx_mode,
  input wire logic [3:0] deser_factor,
  input wire logic phase_hold,
  input wire logic phase_reset,
  input wire logic slip_ctrl,
  input wire logic out_ready,
  input wire logic out_valid,
  input wire logic [lvrx_pkg::WORD_W-1:0] out_word,
  input wire lvrx_pkg::lvrx_bypass_t bypass_out,
  input wire lvrx_pkg::lvrx_status_t status,
  input wire logic slip_rollover,
  input wire logic overflow
);
  import lvrx_pkg::*;
  logic byp;
  logic stall;
  assign byp = rx_mode == LVRX_MODE_BYP_SDR || rx_mode == LVRX_MODE_BYP_DDR;
  assign stall = out_valid && !out_ready;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_slip_edge;
    !slip_ctrl ##1 slip_ctrl;
  endsequence
  a_hold_freeze: assert property (phase_hold && !phase_reset |=> $stable(status.phase))
    else $error("phase moved");
  a_reset_clears: assert property (phase_reset |-> ##[1:2] status == '0)
    else $error("aligner not cleared");
  a_roll_cause: assert property (slip_rollover |-> $past(slip_ctrl) && !$past(slip_ctrl, 2))
    else $error("rollover without slip edge");
  a_roll_pulse: assert property (slip_rollover |=> !slip_rollover)
    else $error("rollover too long");
  a_byp_noslip: assert property ((byp throughout s_slip_edge) |=> !slip_rollover)
    else $error("slip acted in bypass");
  a_byp_noword: assert property (byp |-> !out_valid)
    else $error("word in bypass");
  a_byp_only: assert property (bypass_out.valid |-> byp)
    else $error("bypass data outside bypass");
  a_sdr_one_bit: assert property (bypass_out.valid && rx_mode == LVRX_MODE_BYP_SDR |-> !bypass_out.bits[1])
    else $error("sdr upper bit set");
  a_word_width: assert property (out_valid |-> (out_word >> deser_factor) == '0)
    else $error("bits beyond factor");
  a_static_unlocked: assert property (rx_mode == LVRX_MODE_STATIC |-> !status.locked)
    else $error("lock in static mode");
  a_word_stands: assert property (stall |=> out_valid && $stable(out_word))
    else $error("word lost under stall");
  a_ovf_full: assert property (overflow |-> $past(stall))
    else $error("overflow while draining");
  c_roll: cover property (s_slip_edge ##1 slip_rollover);
endmodule : lvrx_receiver_monitor
bind lvrx_receiver lvrx_receiver_monitor i_lvrx_receiver_monitor (.mclk, .rst_b, .rx_mode, .deser_factor,
  .phase_hold, .phase_reset, .slip_ctrl, .out_ready, .out_valid, .out_word, .bypass_out, .status,
  .slip_rollover, .overflow);
`default_nettype wire

/* File: test/lvrx_tx_model.sv */
`timescale 1ns/100ps
`default_nettype none
module lvrx_tx_model (
  input wire logic go,
  input wire logic [9:0] word,
  input wire logic [3:0] count,
  output logic ser_clk,
  output logic ser_in,
  output logic busy
);
  initial begin
    ser_clk = 1'h0;
    ser_in = 1'h0;
    busy = 1'h0;
  end
  // data moves while the clock is low; the clock stands low between frames
  always @(posedge go) begin
    busy = 1'h1;
    for (int i = 9; i >= 0; i--) begin
      if (i < int'(count)) begin
        ser_in = word[i];
        #62.5 ser_clk = 1'h1;
        #62.5 ser_clk = 1'h0;
      end
    end
    ser_in = ~ser_in;
    busy = 1'h0;
  end
endmodule : lvrx_tx_model
`default_nettype wire

/* File: test/lvrx_receiver_test.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("mismatch %0t got %h want %h", $time, a, b); end end
module lvrx_receiver_test;
  import lvrx_pkg::*;
  logic mclk = 1'h0, rst_b = 1'h0, go = 1'h0, chk_en = 1'h0, out_ready = 1'h1;
  logic phase_hold = 1'h0, phase_reset = 1'h0, sync_reset = 1'h0, slip_ctrl = 1'h0;
  logic out_valid, slip_rollover, overflow;
  logic [3:0] deser_factor = 4'h4, cnt = 4'h4;
  logic [9:0] word = 10'h0, nw = 10'h0, bq = 10'h0;
  logic [7:0] r = 8'h0c;
  logic [WORD_W-1:0] out_word;
  lvrx_mode_t rx_mode = LVRX_MODE_STATIC;
  lvrx_bypass_t bypass_out;
  lvrx_status_t status;
  wire logic ser_clk, ser_in, busy;
  logic [9:0] q[$];
  int failures = 0, checked = 0, rolls = 0, ovfs = 0, pulses = 0;
  lvrx_receiver i_lvrx_receiver (.mclk, .rst_b, .ser_in, .ser_clk, .rx_mode, .deser_factor, .phase_hold,
    .phase_reset, .sync_reset, .slip_ctrl, .out_ready, .out_valid, .out_word, .bypass_out, .status,
    .slip_rollover, .overflow);
  lvrx_tx_model i_lvrx_tx_model (.go, .word, .count(cnt), .ser_clk, .ser_in, .busy);
  initial begin
    forever #5 mclk = ~mclk;
  end
  function automatic logic [9:0] rnd(input logic [3:0] f);
    r = {r[6:0], r[7] ^ r[5] ^ r[4] ^ r[3]};
    return {r[1:0], r} & ((10'h1 << f) - 10'h1);
  endfunction : rnd
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task send(input logic [9:0] w, input logic [3:0] n);
    word = w;
    cnt = n;
    go = 1'h1;
    tick(1);
    go = 1'h0;
    wait (busy === 1'h0);
    tick(1);
  endtask : send
  task restart(input lvrx_mode_t m, input logic [3:0] f);
    rst_b = 1'h0;
    rx_mode = m;
    deser_factor = f;
    tick(3);
    rst_b = 1'h1;
    tick(1);
  endtask : restart
  task test_done();
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  always @(negedge mclk) begin
    if (slip_rollover === 1'h1) rolls++;
    if (overflow === 1'h1) ovfs++;
    if (bypass_out.valid === 1'h1) begin
      pulses++;
      // double rate carries the rising-edge bit in the upper lane
      bq = {bq[8:0], bypass_out.bits[rx_mode == LVRX_MODE_BYP_DDR]};
    end
    if (chk_en && out_valid === 1'h1 && out_ready) begin
      if (q.size() == 0) `CHK(1'h0, 1'h1)
      else `CHK(out_word, q.pop_front())
    end
  end
  initial begin
    #300000;
    failures++;
    test_done();
  end
  initial begin
    tick(10);
    rst_b = 1'h1;
    tick(1);
    chk_en = 1'h1;
    for (int f = 3; f <= 10; f++) begin
      restart(LVRX_MODE_STATIC, f[3:0]);
      repeat (2) begin
        nw = rnd(f[3:0]);
        q.push_back(nw);
        send(nw, f[3:0]);
      end
      tick(4);
      `CHK(q.size(), 0)
    end
    restart(LVRX_MODE_STATIC, 4'h4);
    out_ready = 1'h0;
    repeat (3) begin
      nw = rnd(4'h4);
      if (q.size() < 2) q.push_back(nw);
      send(nw, 4'h4);
    end
    `CHK(ovfs, 1)
    out_ready = 1'h1;
    tick(4);
    `CHK(q.size(), 0)
    for (int k = 1; k <= 4; k++) begin
      slip_ctrl = 1'h1;
      tick(50);
      slip_ctrl = 1'h0;
      tick(50);
      `CHK(rolls, k / 4)
      if (k == 1) begin
        // the slipped bit delays the boundary, so five bits make one word
        nw = rnd(4'h5);
        q.push_back(nw & 10'hf);
        send(nw, 4'h5);
        tick(4);
        `CHK(q.size(), 0)
      end
    end
    for (int m = 0; m < 2; m++) begin
      restart(m ? LVRX_MODE_BYP_DDR : LVRX_MODE_BYP_SDR, 4'h8);
      pulses = 0;
      nw = rnd(4'h8);
      slip_ctrl = 1'h1;
      send(nw, 4'h8);
      slip_ctrl = 1'h0;
      tick(4);
      `CHK(pulses, 8)
      `CHK(bq[7:0], nw[7:0])
    end
    chk_en = 1'h0;
    for (int m = 0; m < 2; m++) begin
      restart(m ? LVRX_MODE_CDR : LVRX_MODE_DPA, 4'ha);
      `CHK(status.locked, 1'h0)
      repeat (4) send(10'h2aa, 4'ha);
      `CHK(status.locked, 1'h1)
      sync_reset = 1'h1;
      phase_reset = 1'h1;
      tick(2);
      sync_reset = 1'h0;
      phase_reset = 1'h0;
      tick(1);
      `CHK(status, 4'h0)
      phase_hold = 1'h1;
      repeat (2) send(10'h2aa, 4'ha);
      `CHK(status.phase, 3'h0)
      phase_hold = 1'h0;
      repeat (4) send(10'h2aa, 4'ha);
      `CHK(status.locked, 1'h1)
    end
    test_done();
  end
endmodule : lvrx_receiver_test
`default_nettype wire
